// ==== rcwl_cfg_store.sv ====
/*
  Three-entry volatile store for unpacked configuration registers, with
  registered read data. Assumes one writer and one reader on sys_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module rcwl_cfg_store
  import rcwl_pkg::*;
(
  input wire logic sys_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic wr_en_i, // Write strobe
  input wire logic [1:0] wr_idx_i, // Write entry
  input wire logic [RCWL_CFG_W-1:0] wr_data_i, // Write data
  input wire logic [1:0] rd_idx_i, // Read entry
  output logic [RCWL_CFG_W-1:0] rd_data_o // Registered read data
);
  logic [RCWL_CFG_W-1:0] mem [RCWL_NWORDS];
  logic [RCWL_CFG_W-1:0] next_mem [RCWL_NWORDS];
  logic [RCWL_CFG_W-1:0] next_rd_data;

  always_comb begin
    next_mem = mem;
    if (wr_en_i) begin
      next_mem[wr_idx_i] = wr_data_i;
    end
    next_rd_data = mem[rd_idx_i];
  end

  // Contents are lost on reset too, so stale values never outlive a reload
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < RCWL_NWORDS; i++) begin
        mem[i] <= RCWL_CFG_RESET;
      end
      rd_data_o <= RCWL_CFG_RESET;
    end else begin
      mem <= next_mem;
      rd_data_o <= next_rd_data;
    end
  end
endmodule // rcwl_cfg_store
`default_nettype wire

// ==== rcwl_flash_model.sv ====
/*
  Flash array model: answers a loader read after dly_i cycles.
  Assumes one read outstanding at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module rcwl_flash_model
  import rcwl_pkg::*;
(
  input wire logic sys_clk_i, // Clock
  input wire logic rst_i, // Drops a pending read
  input wire logic req_i, // Read request
  input wire logic [RCWL_ADDR_W-1:0] addr_i, // Word address
  input wire logic [3:0] dly_i, // Answer delay, at least 1
  input wire logic [RCWL_WORD_W-1:0] w_i [3], // Configuration words 1..3
  output logic valid_o, // Valid pulse
  output logic [RCWL_WORD_W-1:0] data_o // Read data
);
  logic [3:0] cnt = 4'h0;
  logic [RCWL_ADDR_W-1:0] a;
  initial valid_o = 1'b0;
  initial data_o = 24'h00_0000;
  always @(posedge sys_clk_i) begin
    valid_o <= 1'b0;
    data_o <= ~data_o; // Idle data keeps moving so stale words never match
    if (rst_i) cnt <= 4'h0;
    else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        valid_o <= 1'b1;
        // Word locations are reserved: they only ever hold configuration data
        data_o <= a == RCWL_CW1_ADDR ? w_i[0] : a == RCWL_CW2_ADDR ? w_i[1] : w_i[2];
      end
    end else if (req_i) begin
      a <= addr_i;
      cnt <= dly_i;
    end
  end
endmodule // rcwl_flash_model
`default_nettype wire

// ==== rcwl_loader.sv ====
/*
  Reset configuration word loader: on every reset it reads the three flash
  configuration words, unpacks their low 16 bits into configuration
  registers and holds the system in reset until done. Also serves table
  reads of configuration space. Assumes the flash answers a read request
  with a one-cycle valid pulse, from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R01] Programmed configuration bits read zero, unprogrammed read one, as stored.
// [R02] Configuration bits map into configuration space from word address F80000h.
// [R03] Configuration space 800000h-FFFFFFh answers only table reads, not fetches.
// [R04] Configuration registers are volatile, lost at power loss, rebuilt each reset.
// [R05] Every reset of any type copies the three flash words into registers.
// [R06] Packed word images are unpacked across separate configuration register outputs.
// [R07] Words one, two, three are fetched from ABFEh, ABFCh, ABFAh.
// [R08] Upper byte of each word has no bits behind it; ignored.
// [R09] Software should fill upper bytes with ones so they decode as no-ops.
// [R10] Erasing the last page clears the words, enabling code protection next load.
// [R11] Software should reserve word locations and avoid erasing the last page.
// [R12] System reset is held until all three words are loaded and unpacked.
module rcwl_loader
  import rcwl_pkg::*;
(
  input wire logic sys_clk_i, // System clock, 250 MHz
  input wire logic rst_i, // Any device reset, synchronous
  output logic fl_rd_req_o, // Flash read request
  output logic [RCWL_ADDR_W-1:0] fl_rd_addr_o, // Flash word address
  input wire logic fl_rd_valid_i, // Flash read data valid pulse
  input wire logic [RCWL_WORD_W-1:0] fl_rd_data_i, // Flash read data
  input wire logic tbl_rd_i, // Table read strobe
  input wire logic fetch_i, // Instruction fetch or data access strobe
  input wire logic [RCWL_ADDR_W-1:0] acc_addr_i, // Access address
  output logic [RCWL_CFG_W-1:0] tbl_data_o, // Table read data
  output logic tbl_valid_o, // Table read data valid
  output logic cfg_fault_o, // Fetch hit configuration space
  output logic [RCWL_CFG_W-1:0] cfg_word1_o, // Unpacked configuration word 1
  output logic [RCWL_CFG_W-1:0] cfg_word2_o, // Unpacked configuration word 2
  output logic [RCWL_CFG_W-1:0] cfg_word3_o, // Unpacked configuration word 3
  output logic code_prot_o, // Code protection active
  output logic sys_rst_o // Reset held to the rest of the device
);
  rcwl_state_type state, next_state;
  logic [1:0] idx, next_idx;
  logic [RCWL_CFG_W-1:0] w1, w2, w3, next_w1, next_w2, next_w3;
  logic [1:0] rd_idx;
  logic tbl_pend, next_tbl_pend;
  logic fault, next_fault;
  logic [RCWL_CFG_W-1:0] store_q;

  function automatic logic [RCWL_ADDR_W-1:0] word_addr(input logic [1:0] i);
    if (i == 2'h0) begin
      word_addr = RCWL_CW1_ADDR; // R07
    end else if (i == 2'h1) begin
      word_addr = RCWL_CW2_ADDR; // R07
    end else begin
      word_addr = RCWL_CW3_ADDR; // R07
    end
  endfunction

  function automatic logic in_cfg_space(input logic [RCWL_ADDR_W-1:0] a);
    in_cfg_space = (a >= RCWL_CFG_SPACE_LO) && (a <= RCWL_CFG_SPACE_HI);
  endfunction

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_w1 = w1;
    next_w2 = w2;
    next_w3 = w3;
    case (state)
      RCWL_S_REQ: begin
        next_state = RCWL_S_WAIT;
      end
      RCWL_S_WAIT: begin
        if (fl_rd_valid_i) begin
          // Upper byte dropped: no configuration bits live there
          if (idx == 2'h0) next_w1 = fl_rd_data_i[RCWL_CFG_W-1:0]; // R06 R08
          if (idx == 2'h1) next_w2 = fl_rd_data_i[RCWL_CFG_W-1:0]; // R06 R08
          if (idx == RCWL_IDX_LAST) next_w3 = fl_rd_data_i[RCWL_CFG_W-1:0]; // R06 R08
          if (idx == RCWL_IDX_LAST) begin
            next_state = RCWL_S_DONE;
          end else begin
            next_idx = idx + 2'h1;
            next_state = RCWL_S_REQ;
          end
        end
      end
      RCWL_S_DONE: begin
        next_state = RCWL_S_IDLE;
      end
      RCWL_S_IDLE: begin
        next_state = RCWL_S_IDLE;
      end
      default: begin
        next_state = RCWL_S_REQ;
      end
    endcase
  end

  // Every reset restarts the load; registers are volatile
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= RCWL_S_REQ; // R05 R04
      idx <= RCWL_IDX_FIRST;
      w1 <= RCWL_CFG_RESET;
      w2 <= RCWL_CFG_RESET;
      w3 <= RCWL_CFG_RESET;
    end else begin
      state <= next_state;
      idx <= next_idx;
      w1 <= next_w1;
      w2 <= next_w2;
      w3 <= next_w3;
    end
  end

  assign fl_rd_req_o = (state == RCWL_S_REQ);
  assign fl_rd_addr_o = word_addr(idx); // R07
  assign sys_rst_o = (state != RCWL_S_IDLE); // R12

  // Bits keep their stored polarity: programmed 0, unprogrammed 1
  assign cfg_word1_o = w1; // R01
  assign cfg_word2_o = w2; // R01
  assign cfg_word3_o = w3; // R01
  // Erased words read all zero, which turns protection on
  assign code_prot_o = ~w1[RCWL_PROT_BIT]; // R10

  // Table reads of configuration space; index taken from the low bits
  always_comb begin
    next_tbl_pend = 1'b0;
    next_fault = 1'b0;
    rd_idx = 2'h0;
    if (acc_addr_i >= RCWL_CFG_BITS_BASE) begin
      rd_idx = (acc_addr_i[2:1] > RCWL_IDX_LAST) ? RCWL_IDX_LAST : acc_addr_i[2:1]; // R02
    end
    if (!sys_rst_o && tbl_rd_i && in_cfg_space(acc_addr_i)) begin
      next_tbl_pend = 1'b1; // R03
    end
    if (!sys_rst_o && fetch_i && in_cfg_space(acc_addr_i)) begin
      next_fault = 1'b1; // R03
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tbl_pend <= 1'b0;
      fault <= 1'b0;
    end else begin
      tbl_pend <= next_tbl_pend;
      fault <= next_fault;
    end
  end

  rcwl_cfg_store u_store (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_en_i(state == RCWL_S_WAIT && fl_rd_valid_i),
    .wr_idx_i(idx),
    .wr_data_i(fl_rd_data_i[RCWL_CFG_W-1:0]),
    .rd_idx_i(rd_idx),
    .rd_data_o(store_q)
  );

  assign tbl_valid_o = tbl_pend;
  assign tbl_data_o = tbl_pend ? store_q : RCWL_ERASED;
  assign cfg_fault_o = fault;
endmodule // rcwl_loader
`default_nettype wire

// ==== rcwl_loader_asserts.sv ====
/*
  Checker for the configuration word loader, bound to its ports.
  Assumes one clock domain and the flash answering only in WAIT.
*/
`timescale 1ns/1ps
`default_nettype none
module rcwl_loader_asserts
  import rcwl_pkg::*;
(
  input wire logic sys_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic fl_rd_req_o, // Flash request
  input wire logic [RCWL_ADDR_W-1:0] fl_rd_addr_o, // Flash address
  input wire logic fl_rd_valid_i, // Flash valid
  input wire logic tbl_rd_i, // Table read
  input wire logic fetch_i, // Fetch
  input wire logic [RCWL_ADDR_W-1:0] acc_addr_i, // Access address
  input wire logic tbl_valid_o, // Table answer
  input wire logic cfg_fault_o, // Fetch fault
  input wire logic [RCWL_CFG_W-1:0] cfg_word1_o, // Word 1
  input wire logic code_prot_o, // Protection
  input wire logic sys_rst_o // Held reset
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_first_req: assert property ($past(rst_i) |->
    fl_rd_req_o && fl_rd_addr_o == RCWL_CW1_ADDR) else $error("first read not word 1");
  a_req_pulse: assert property (fl_rd_req_o |=> !fl_rd_req_o)
    else $error("request wider than one cycle");
  a_addr_step: assert property (fl_rd_valid_i && sys_rst_o && fl_rd_addr_o == RCWL_CW1_ADDR
    |=> fl_rd_req_o && fl_rd_addr_o == RCWL_CW2_ADDR) else $error("word 2 not next");
  a_rst_release: assert property (fl_rd_valid_i && sys_rst_o &&
    fl_rd_addr_o == RCWL_CW3_ADDR |=> sys_rst_o ##1 !sys_rst_o) else $error("late release");
  a_rst_stays: assert property (!sys_rst_o |=> !sys_rst_o)
    else $error("held reset came back");
  a_prot_bit: assert property (code_prot_o == !cfg_word1_o[RCWL_PROT_BIT])
    else $error("protection mismatch");
  a_tbl_refuse: assert property (!(tbl_rd_i && acc_addr_i[23] && !sys_rst_o)
    |=> !tbl_valid_o) else $error("answer without table read");
  a_fetch_fault: assert property (fetch_i && acc_addr_i[23] && !sys_rst_o
    |=> cfg_fault_o && !tbl_valid_o) else $error("fetch not refused");
endmodule // rcwl_loader_asserts
bind rcwl_loader rcwl_loader_asserts u_chk (.sys_clk_i, .rst_i, .fl_rd_req_o, .fl_rd_addr_o,
  .fl_rd_valid_i, .tbl_rd_i, .fetch_i, .acc_addr_i, .tbl_valid_o, .cfg_fault_o,
  .cfg_word1_o, .code_prot_o, .sys_rst_o);
`default_nettype wire

// ==== rcwl_pkg.sv ====
/*
  Constants shared by the configuration word loader: flash addresses of the
  configuration words, configuration space bounds, word layout and states.
  Assumes a 24-bit program word and word-granular flash addressing.
*/
`default_nettype none
package rcwl_pkg;
  localparam int RCWL_ADDR_W = 24;
  localparam int RCWL_WORD_W = 24;
  localparam int RCWL_CFG_W = 16;
  localparam int RCWL_NWORDS = 3;
  localparam logic [RCWL_ADDR_W-1:0] RCWL_CW1_ADDR = 24'h00_ABFE;
  localparam logic [RCWL_ADDR_W-1:0] RCWL_CW2_ADDR = 24'h00_ABFC;
  localparam logic [RCWL_ADDR_W-1:0] RCWL_CW3_ADDR = 24'h00_ABFA;
  localparam logic [RCWL_ADDR_W-1:0] RCWL_CFG_SPACE_LO = 24'h80_0000;
  localparam logic [RCWL_ADDR_W-1:0] RCWL_CFG_BITS_BASE = 24'hF8_0000;
  localparam logic [RCWL_ADDR_W-1:0] RCWL_CFG_SPACE_HI = 24'hFF_FFFF;
  localparam logic [RCWL_CFG_W-1:0] RCWL_CFG_RESET = 16'hFFFF;
  localparam logic [RCWL_CFG_W-1:0] RCWL_ERASED = 16'h0000;
  localparam logic [1:0] RCWL_IDX_LAST = 2'h2;
  localparam logic [1:0] RCWL_IDX_FIRST = 2'h0;
  localparam int RCWL_PROT_BIT = 0;
  typedef enum logic [3:0] {
    RCWL_S_REQ  = 4'b0001,
    RCWL_S_WAIT = 4'b0010,
    RCWL_S_DONE = 4'b0100,
    RCWL_S_IDLE = 4'b1000
  } rcwl_state_type;
endpackage
`default_nettype wire

// ==== tb_top.sv ====
/*
  Bench for the loader: random words, erased page, reset mid-load,
  table reads and fetches. Assumes the flash model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rcwl_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, tbl_rd_i = 0, fetch_i = 0, req, vld, tv, flt, cp, srst;
  logic [23:0] acc_addr_i = 0, addr, fd, w [3];
  logic [15:0] td, c1, c2, c3;
  logic [3:0] dly = 4'h1;
  logic [31:0] seed = 32'h0000_1675;
  int num_errors = 0;
  int samples_checked = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  rcwl_flash_model fm (.sys_clk_i, .rst_i, .req_i(req), .addr_i(addr), .dly_i(dly),
    .w_i(w), .valid_o(vld), .data_o(fd));
  rcwl_loader dut (.sys_clk_i, .rst_i, .fl_rd_req_o(req), .fl_rd_addr_o(addr),
    .fl_rd_valid_i(vld), .fl_rd_data_i(fd), .tbl_rd_i, .fetch_i, .acc_addr_i,
    .tbl_data_o(td), .tbl_valid_o(tv), .cfg_fault_o(flt), .cfg_word1_o(c1),
    .cfg_word2_o(c2), .cfg_word3_o(c3), .code_prot_o(cp), .sys_rst_o(srst));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input string n, input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task finish_test();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task op(input logic t, input logic [23:0] a);
    @(posedge sys_clk_i);
    tbl_rd_i <= t;
    fetch_i <= !t;
    acc_addr_i <= a;
    @(posedge sys_clk_i);
    tbl_rd_i <= 1'b0;
    fetch_i <= 1'b0;
    #1;
  endtask
  task load(input logic mid);
    rst_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    if (mid) begin
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b1; // Reset in mid-load must restart from word 1
      w[0] = w[0] ^ 24'h00_00FF;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
    end
    for (int i = 0; i < 500 && srst !== 1'b0; i++) @(posedge sys_clk_i);
    if (srst !== 1'b0) begin
      chk("load_timeout", 24'h1, 24'h0);
      finish_test();
    end
  endtask
  initial begin
    for (int n = 0; n < 4; n++) begin
      foreach (w[k]) w[k] = rnd();
      if (n == 1) foreach (w[k]) w[k][23:16] = 8'hFF;
      if (n == 2) w = '{default: 24'h00_0000}; // Erased last page
      dly <= 4'(rnd() % 5 + 1);
      load(n == 3);
      chk("word1", c1, w[0][15:0]);
      chk("word2", c2, w[1][15:0]);
      chk("word3", c3, w[2][15:0]);
      chk("prot", cp, !w[0][RCWL_PROT_BIT]);
      for (int k = 0; k < 3; k++) begin
        op(1'b1, RCWL_CFG_BITS_BASE + 24'(2 * k));
        chk("tbl", {tv, td}, {1'b1, w[k][15:0]});
      end
      op(1'b1, RCWL_CFG_SPACE_LO);
      chk("tbl_low", {tv, td}, {1'b1, w[0][15:0]});
      op(1'b1, {8'h00, rnd() >> 16});
      chk("user_tbl", tv, 1'b0);
      op(1'b0, RCWL_CFG_SPACE_LO | 24'(rnd()));
      chk("fetch", {flt, tv}, 2'b10);
      $display("test %0d done", n);
    end
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
